// File: hw/scfr_pkg.sv
// Package with register indices, field layouts, scan types and oversampling codes for the scan control block.
package scfr_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] CTRL_IDX   = 8'h66;  // Scan control word.
   localparam logic [7:0] STAT_IDX   = 8'h68;  // Busy, done and alert status.
   localparam logic [7:0] OVTH_IDX   = 8'h69;  // Overvoltage threshold.
   localparam logic [7:0] UVTH_IDX   = 8'h6A;  // Undervoltage threshold.
   localparam logic [7:0] TOTAL_IDX  = 8'h70;  // Sum of cell results.
   localparam logic [7:0] LOW_IDX    = 8'h71;  // Lowest cell result.
   localparam logic [7:0] HIGH_IDX   = 8'h72;  // Highest cell result.
   localparam logic [7:0] SPREAD_IDX = 8'h73;  // Highest minus lowest.
   localparam logic [7:0] RES_IDX    = 8'h40;  // First channel readback word.
   // Control word field positions.
   localparam int SCAN_BIT   = 0;
   localparam int ORDER_BIT  = 1;
   localparam int OSR_LSB    = 3;
   localparam int TYPE_LSB   = 6;
   localparam int RDSEL_BIT  = 9;
   localparam int AMEND_BIT  = 10;
   localparam logic [15:0] CTRL_WMASK = 16'h07FA;  // Writable control bits.
   localparam logic [15:0] CTRL_RST   = 16'h0000;  // Control reset value.
   // Status word field positions.
   localparam int BUSY_BIT = 0;
   localparam int DONE_BIT = 1;
   localparam int OV_BIT   = 2;
   localparam int UV_BIT   = 3;
   // Forced oversampling code in balancing modes, and code for a single acquisition.
   localparam logic [2:0] OSR_BAL  = 3'h3;
   localparam logic [2:0] OSR_NONE = 3'h0;
   // Scan types.
   typedef enum logic [2:0] {
      SCFR_ADC      = 3'b000,
      SCFR_ADC_COMP = 3'b001,
      SCFR_COMP     = 3'b010,
      SCFR_CAL      = 3'b011,
      SCFR_SW_SHORT = 3'b100,
      SCFR_SW_OPEN  = 3'b101,
      SCFR_OPEN_ODD = 3'b110,
      SCFR_OPEN_EVN = 3'b111
   } scfr_type_t;
endpackage : scfr_pkg

// File: hw/scfr_mem.sv
// Small synchronous memory with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none
module scfr_mem #(
   parameter int W  = 16,  // Word width.
   parameter int D  = 16,  // Number of words.
   parameter int AW = 4    // Address width.
) (
   input  wire logic          clk,    // Clock.
   input  wire logic          rst_n,  // Asynchronous reset, active low.
   input  wire logic          we,     // Write enable.
   input  wire logic [AW-1:0] waddr,  // Write address.
   input  wire logic [W-1:0]  wdata,  // Write data.
   input  wire logic [AW-1:0] raddr,  // Read address.
   output logic      [W-1:0]  rdata   // Read data, one cycle after raddr.
);
   logic [W-1:0] mem [D];  // Storage array, cleared by reset.

   // Write port; reset clears every word, since an unknown accumulator would poison every filtered result.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < D; i++) begin
            mem[i] <= '0;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read port; an out-of-range address reads zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (int'(raddr) < D) begin
         rdata <= mem[raddr];
      end else begin
         rdata <= '0;
      end
   end
endmodule : scfr_mem
`default_nettype wire

// File: hw/scfr_top.sv
// Scan type decode, IIR amend and filtered readback control with an AHB-Lite register slave.
// Behaviour
// - Amend set: scaled difference between result and accumulator added into accumulator.
// - Amend clear: accumulators untouched at sequence end.
// - Balancing modes force amend enable to one.
// - Readback loads filtered or unfiltered per select.
// - Select sampled at request steers derived results.
// - Three-bit scan type decoded into eight kinds.
// - Comparator scans always run pyramid order.
// - Comparator scans unipolar, bipolar channels skipped.
// - Calibration rewrites five coefficients, nothing else.
// - Balancing modes force ADC-only scan type.
// - Oversampling applied wherever it is meaningful.
// - Diagnostic scan types override measurement configuration.
// - Scan strobe self-clears and reads zero.
`timescale 1ns/1ns
`default_nettype none
module scfr_top
   import scfr_pkg::*;
#(
   parameter int NCH = 15,  // Channels; the last one is the block channel.
   parameter int DW  = 14,  // Conversion result width.
   parameter int IIR_SHIFT = 2  // Filter weight as a right shift.
) (
   input  wire logic          hclk,         // Bus and block clock.
   input  wire logic          hresetn,      // Asynchronous reset, active low.
   input  wire logic          hsel,         // AHB slave select.
   input  wire logic [31:0]   haddr,        // AHB address.
   input  wire logic [1:0]    htrans,       // AHB transfer type.
   input  wire logic          hwrite,       // AHB write flag.
   input  wire logic [2:0]    hsize,        // AHB size, word only.
   input  wire logic [31:0]   hwdata,       // AHB write data.
   input  wire logic          hready,       // AHB bus ready.
   output logic               hreadyout,    // AHB slave ready.
   output logic               hresp,        // AHB response, always OKAY.
   output logic [31:0]        hrdata,       // AHB read data.
   input  wire logic          balance_mode, // Automated balancing is active.
   input  wire logic [NCH-1:0] bipolar_mask, // Channels set up for bipolar.
   output logic               conv_req,     // Conversion request pulse.
   output logic [3:0]         conv_chan,    // Channel to convert.
   output logic               conv_comp,    // Conversion uses the comparator.
   output logic               conv_adc,     // Conversion uses the ADC.
   output logic               conv_unipolar,// Polarity forced unipolar.
   input  wire logic          conv_done,    // Conversion finished pulse.
   input  wire logic [DW-1:0] conv_data,    // Conversion result.
   output logic               cal_start,    // Calibration routine start pulse.
   input  wire logic          cal_done,     // Calibration finished pulse.
   output logic [2:0]         oversample_ratio, // Effective oversampling code.
   output logic               ramp_order,   // High selects ramp order.
   output logic [2:0]         diag_override,// Diagnostic override kind, zero when none.
   output logic               scan_busy     // A sequence is running.
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // True when the scan type produces ADC results.
   function automatic logic has_adc(input scfr_type_t t);
      return (t != SCFR_COMP) && (t != SCFR_CAL);
   endfunction : has_adc

   // True when the scan type uses the comparator.
   function automatic logic is_comp(input scfr_type_t t);
      return (t == SCFR_ADC_COMP) || (t == SCFR_COMP);
   endfunction : is_comp

   // One IIR step: move the accumulator a scaled part of the way to the new result.
   function automatic logic [DW-1:0] iir_step(input logic [DW-1:0] acc, input logic [DW-1:0] x);
      logic signed [DW:0] diff;
      diff = $signed({1'b0, x}) - $signed({1'b0, acc});
      return DW'($signed({1'b0, acc}) + (diff >>> IIR_SHIFT));
   endfunction : iir_step

   localparam logic [3:0] LAST_CH = 4'(NCH - 1);  // Block channel index.

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave.

   logic       wr_pend_reg;  // Write data phase in progress.
   logic       rd_pend_reg;  // First read data phase cycle.
   logic       rd_last_reg;  // Second read data phase cycle, data valid.
   logic [7:0] idx_reg;      // Register index of the pending transfer.
   logic       rd_mem_reg;   // Pending read targets the readback memory.
   logic [31:0] rd_q_reg;    // Registered read data for ordinary registers.
   logic       take;         // Address phase accepted this edge.
   logic [DW-1:0] rb_rdata;  // Readback memory output.

   assign take = hsel && htrans[1] && hready;

   // Capture address phase; reads get one wait state for the memory.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rd_last_reg <= 1'b0;
         idx_reg     <= 8'h00;
      end else begin
         rd_last_reg <= rd_pend_reg;
         if (hreadyout) begin
            wr_pend_reg <= take && hwrite;
            rd_pend_reg <= take && !hwrite;
            if (take) begin
               idx_reg <= haddr[9:2];
            end
         end else begin
            rd_pend_reg <= 1'b0;
         end
      end
   end

   assign hreadyout = !rd_pend_reg;
   assign hresp     = 1'b0;
   assign hrdata    = rd_mem_reg ? 32'(rb_rdata) : rd_q_reg;

   logic wr_ctrl;  // Control word write this cycle.
   logic wr_stat;  // Status word write this cycle.
   assign wr_ctrl = wr_pend_reg && (idx_reg == CTRL_IDX);
   assign wr_stat = wr_pend_reg && (idx_reg == STAT_IDX);

   ////////////////////////////////////////////////////////////////////////////
   // Software-visible registers.

   logic [15:0]   ctrl_reg;     // Stored control fields; the strobe is never stored.
   logic [DW-1:0] ov_thr_reg;   // Overvoltage threshold.
   logic [DW-1:0] uv_thr_reg;   // Undervoltage threshold.
   logic          done_reg;     // Sequence complete, write zero to clear.
   logic          ov_reg;       // Overvoltage seen in the last scan.
   logic          uv_reg;       // Undervoltage seen in the last scan.
   logic [DW+3:0] total_reg;    // Sum of cell results.
   logic [DW-1:0] low_reg;      // Lowest cell result.
   logic [DW-1:0] high_reg;     // Highest cell result.
   logic          seq_end;      // Sequence completes this cycle.
   logic          scan_req;     // Accepted scan request this cycle.

   // Control fields; the strobe bit is masked so it always reads zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= hwdata[15:0] & CTRL_WMASK;
      end
   end

   // Alert thresholds.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ov_thr_reg <= '1;
         uv_thr_reg <= '0;
      end else if (wr_pend_reg) begin
         if (idx_reg == OVTH_IDX) begin
            ov_thr_reg <= hwdata[DW-1:0];
         end
         if (idx_reg == UVTH_IDX) begin
            uv_thr_reg <= hwdata[DW-1:0];
         end
      end
   end

   // Done flag: completion sets it and wins over a clearing write in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
      end else if (seq_end) begin
         done_reg <= 1'b1;
      end else if (wr_stat && !hwdata[DONE_BIT]) begin
         done_reg <= 1'b0;
      end
   end

   // A strobe is honoured only when idle and done is clear; other fields are still taken.
   assign scan_req = wr_ctrl && hwdata[SCAN_BIT] && !scan_busy && !done_reg;

   // Read data for ordinary registers, captured in the first data phase cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q_reg   <= 32'h0000_0000;
         rd_mem_reg <= 1'b0;
      end else if (rd_pend_reg) begin
         rd_mem_reg <= (idx_reg >= RES_IDX) && (idx_reg < RES_IDX + 8'(NCH));
         case (idx_reg)
            CTRL_IDX:   rd_q_reg <= 32'(ctrl_reg);
            STAT_IDX:   rd_q_reg <= 32'({uv_reg, ov_reg, done_reg, scan_busy});
            OVTH_IDX:   rd_q_reg <= 32'(ov_thr_reg);
            UVTH_IDX:   rd_q_reg <= 32'(uv_thr_reg);
            TOTAL_IDX:  rd_q_reg <= 32'(total_reg);
            LOW_IDX:    rd_q_reg <= 32'(low_reg);
            HIGH_IDX:   rd_q_reg <= 32'(high_reg);
            SPREAD_IDX: rd_q_reg <= 32'(high_reg - low_reg);
            default:    rd_q_reg <= 32'h0000_0000;
         endcase
      end else if (rd_last_reg) begin
         rd_mem_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings captured at the scan request and held for the whole sequence.

   scfr_type_t t_reg;      // Effective scan type.
   logic       amend_reg;  // Effective amend enable.
   logic       rdsel_reg;  // Sampled filtered readback select.
   logic [2:0] osr_reg;    // Effective oversampling code.
   logic       ramp_reg;   // Effective scan order.

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t_reg     <= SCFR_ADC;
         amend_reg <= 1'b0;
         rdsel_reg <= 1'b0;
         osr_reg   <= OSR_NONE;
         ramp_reg  <= 1'b0;
      end else if (scan_req) begin
         rdsel_reg <= hwdata[RDSEL_BIT];
         if (balance_mode) begin
            t_reg     <= SCFR_ADC;
            amend_reg <= 1'b1;
            osr_reg   <= OSR_BAL;
            ramp_reg  <= 1'b0;
         end else begin
            t_reg     <= scfr_type_t'(hwdata[TYPE_LSB+:3]);
            amend_reg <= hwdata[AMEND_BIT];
            // Calibration ignores oversampling; every other kind uses it.
            osr_reg   <= (hwdata[TYPE_LSB+:3] == SCFR_CAL) ? OSR_NONE : hwdata[OSR_LSB+:3];
            // Comparator and calibration scans cannot run in ramp order.
            ramp_reg  <= hwdata[ORDER_BIT] && !is_comp(scfr_type_t'(hwdata[TYPE_LSB+:3]))
                         && (hwdata[TYPE_LSB+:3] != SCFR_CAL);
         end
      end
   end

   assign oversample_ratio = osr_reg;
   assign ramp_order       = ramp_reg;
   // Diagnostic kinds override the rest of the measurement setup while busy.
   assign diag_override    = (scan_busy && t_reg[2]) ? t_reg : 3'h0;
   assign conv_comp        = is_comp(t_reg);
   assign conv_adc         = has_adc(t_reg);
   assign conv_unipolar    = is_comp(t_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   typedef enum logic [2:0] {
      SCFR_IDLE = 3'b000,
      SCFR_CALW = 3'b001,
      SCFR_CONV = 3'b010,
      SCFR_WAIT = 3'b011,
      SCFR_URD  = 3'b100,
      SCFR_UWR  = 3'b101
   } scfr_state_t;

   scfr_state_t st_reg;    // Sequencer state.
   logic [3:0]  ch_reg;    // Current channel.
   logic [NCH-1:0] skip_reg;  // Channels skipped in this scan.
   logic [2*DW-1:0] ch_rdata;  // Accumulator and raw result of a channel.
   logic [DW-1:0]   acc_new;   // Accumulator after amending.
   logic [DW-1:0]   src;       // Value feeding readback and derived results.
   logic            upd_we;    // Write back in the update pass.
   logic            conv_we;   // Store a fresh raw result.
   logic            skip_now;  // Current channel is skipped.

   assign skip_now = is_comp(t_reg) && bipolar_mask[ch_reg];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg   <= SCFR_IDLE;
         ch_reg   <= 4'h0;
         skip_reg <= '0;
      end else begin
         case (st_reg)
            SCFR_IDLE: begin
               ch_reg   <= 4'h0;
               skip_reg <= '0;
               if (scan_req) begin
                  // Calibration takes no measurements at all.
                  st_reg <= (hwdata[TYPE_LSB+:3] == SCFR_CAL && !balance_mode) ? SCFR_CALW : SCFR_CONV;
               end
            end
            SCFR_CALW: begin
               if (cal_done) begin
                  st_reg <= SCFR_IDLE;
               end
            end
            SCFR_CONV: begin
               if (skip_now) begin
                  skip_reg[ch_reg] <= 1'b1;
                  ch_reg <= (ch_reg == LAST_CH) ? 4'h0 : ch_reg + 4'h1;
                  st_reg <= (ch_reg == LAST_CH) ? SCFR_URD : SCFR_CONV;
               end else begin
                  st_reg <= SCFR_WAIT;
               end
            end
            SCFR_WAIT: begin
               if (conv_done) begin
                  ch_reg <= (ch_reg == LAST_CH) ? 4'h0 : ch_reg + 4'h1;
                  st_reg <= (ch_reg == LAST_CH) ? SCFR_URD : SCFR_CONV;
               end
            end
            SCFR_URD: begin
               st_reg <= SCFR_UWR;
            end
            SCFR_UWR: begin
               ch_reg <= ch_reg + 4'h1;
               st_reg <= (ch_reg == LAST_CH) ? SCFR_IDLE : SCFR_URD;
            end
            default: begin
               st_reg <= SCFR_IDLE;
            end
         endcase
      end
   end

   assign scan_busy = (st_reg != SCFR_IDLE);
   assign seq_end   = ((st_reg == SCFR_CALW) && cal_done) || ((st_reg == SCFR_UWR) && (ch_reg == LAST_CH));
   assign conv_req  = (st_reg == SCFR_CONV) && !skip_now;
   assign conv_chan = ch_reg;
   assign cal_start = (st_reg == SCFR_IDLE) && scan_req && (hwdata[TYPE_LSB+:3] == SCFR_CAL) && !balance_mode;
   assign conv_we   = (st_reg == SCFR_WAIT) && conv_done && has_adc(t_reg);

   // Amend only when enabled and the scan produced an ADC result.
   assign acc_new = (amend_reg && has_adc(t_reg)) ? iir_step(ch_rdata[2*DW-1:DW], ch_rdata[DW-1:0])
                                                 : ch_rdata[2*DW-1:DW];
   assign src     = rdsel_reg ? acc_new : ch_rdata[DW-1:0];
   assign upd_we  = (st_reg == SCFR_UWR) && !skip_reg[ch_reg] && has_adc(t_reg);

   // Accumulator of the current channel, kept while its raw half is rewritten.
   logic [DW-1:0] ch_rdata_acc_hold;
   assign ch_rdata_acc_hold = ch_rdata[2*DW-1:DW];

   // Per-channel accumulator and raw result; the raw half is written as results arrive.
   scfr_mem #(.W(2 * DW), .D(NCH), .AW(4)) u_chan (
      .clk   (hclk),
      .rst_n (hresetn),
      .we    (conv_we || upd_we),
      .waddr (ch_reg),
      .wdata (conv_we ? {ch_rdata_acc_hold, conv_data} : {acc_new, ch_rdata[DW-1:0]}),
      .raddr (ch_reg),
      .rdata (ch_rdata)
   );

   // Readback words loaded from the chosen source in the update pass.
   scfr_mem #(.W(DW), .D(NCH), .AW(4)) u_rb (
      .clk   (hclk),
      .rst_n (hresetn),
      .we    (upd_we),
      .waddr (ch_reg),
      .wdata (src),
      .raddr (4'(idx_reg - RES_IDX)),
      .rdata (rb_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Derived results and alerts from the source chosen at the request.

   logic cell_upd;  // A cell channel is being loaded.
   assign cell_upd = upd_we && (ch_reg != LAST_CH);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         total_reg <= '0;
         low_reg   <= '1;
         high_reg  <= '0;
         ov_reg    <= 1'b0;
         uv_reg    <= 1'b0;
      end else if (scan_req && (balance_mode || has_adc(scfr_type_t'(hwdata[TYPE_LSB+:3])))) begin
         // Start fresh for a scan that will deliver ADC results; balancing always does.
         total_reg <= '0;
         low_reg   <= '1;
         high_reg  <= '0;
         ov_reg    <= 1'b0;
         uv_reg    <= 1'b0;
      end else if (cell_upd) begin
         total_reg <= total_reg + (DW+4)'(src);
         low_reg   <= (src < low_reg) ? src : low_reg;
         high_reg  <= (src > high_reg) ? src : high_reg;
         ov_reg    <= ov_reg || (src > ov_thr_reg);
         uv_reg    <= uv_reg || (src < uv_thr_reg);
      end
   end
endmodule : scfr_top
`default_nettype wire

// File: tb/scfr_sva.sv
// Assertion checker for the scan control block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module scfr_sva
   import scfr_pkg::*;
#(
   parameter int NCH = 15  // Channels, as in the design.
) (
   input wire logic           hclk,             // Clock.
   input wire logic           hresetn,          // Reset, active low.
   input wire logic           hsel,             // Slave select.
   input wire logic [1:0]     htrans,           // Transfer type.
   input wire logic           hwrite,           // Write flag.
   input wire logic           hready,           // Bus ready.
   input wire logic           hreadyout,        // Slave ready.
   input wire logic           hresp,            // Response.
   input wire logic           balance_mode,     // Balancing active.
   input wire logic [NCH-1:0] bipolar_mask,     // Bipolar channels.
   input wire logic           conv_req,         // Conversion request.
   input wire logic [3:0]     conv_chan,        // Channel.
   input wire logic           conv_comp,        // Comparator used.
   input wire logic           conv_adc,         // ADC used.
   input wire logic           conv_unipolar,    // Unipolar forced.
   input wire logic           cal_start,        // Calibration start.
   input wire logic [2:0]     oversample_ratio, // Effective code.
   input wire logic           ramp_order,       // Ramp order.
   input wire logic [2:0]     diag_override,    // Diagnostic kind.
   input wire logic           scan_busy         // Sequence running.
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A read costs exactly one wait state, which the bus master depends on.
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   // Calibration must not start conversions behind the routine's back.
   sequence cal_quiet;
      scan_busy && !conv_req ##1 (!conv_req) [*3];
   endsequence
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> one_wait) else $error("read wait wrong");
   write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stalled");
   held_cfg_a: assert property (scan_busy && $past(scan_busy) |->
      $stable({diag_override, conv_comp, conv_adc, oversample_ratio, ramp_order})) else $error("config moved");
   comp_pyramid_a: assert property (scan_busy && conv_comp |-> !ramp_order) else $error("comp in ramp");
   comp_unipolar_a: assert property (scan_busy && conv_comp |-> conv_unipolar) else $error("comp bipolar");
   skip_bipolar_a: assert property (conv_req && conv_comp |-> !bipolar_mask[conv_chan]) else $error("no skip");
   cal_only_a: assert property (cal_start |=> cal_quiet) else $error("calibration converted");
   bal_force_a: assert property ($rose(scan_busy) && $past(balance_mode) |-> conv_adc && !conv_comp
      && oversample_ratio == OSR_BAL && !ramp_order) else $error("balancing not forced");
   diag_idle_a: assert property (!scan_busy |-> diag_override == 3'h0) else $error("override when idle");
endmodule : scfr_sva
bind scfr_top scfr_sva #(.NCH(NCH)) i_scfr_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .balance_mode(balance_mode),
   .bipolar_mask(bipolar_mask), .conv_req(conv_req), .conv_chan(conv_chan), .conv_comp(conv_comp),
   .conv_adc(conv_adc), .conv_unipolar(conv_unipolar), .cal_start(cal_start),
   .oversample_ratio(oversample_ratio), .ramp_order(ramp_order), .diag_override(diag_override),
   .scan_busy(scan_busy));
`default_nettype wire

// File: tb/test_scan_config_filter_routing.sv
// Directed testbench for the scan control block.
`timescale 1ns/1ns
`default_nettype none
module test_scan_config_filter_routing;
   import scfr_pkg::*;
   localparam int NCH = 15;
   logic hclk = 0, hresetn = 0, hwrite = 0, hreadyout, hresp, balance_mode = 0, conv_req, conv_done = 0;
   logic conv_comp, conv_adc, conv_unipolar, cal_start, cal_done = 0, ramp_order, scan_busy;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic [14:0] bipolar_mask = 0;
   logic [13:0] conv_data = 0;
   logic [3:0]  conv_chan;
   logic [2:0]  oversample_ratio, diag_override, b_osr, b_diag;
   logic        b_ramp, b_comp, b_adc, b_uni;
   int          nreq, ncal, err_count = 0, samples_checked = 0;
   scfr_top i_scfr_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .balance_mode(balance_mode), .bipolar_mask(bipolar_mask),
      .conv_req(conv_req), .conv_chan(conv_chan), .conv_comp(conv_comp), .conv_adc(conv_adc),
      .conv_unipolar(conv_unipolar), .conv_done(conv_done), .conv_data(conv_data), .cal_start(cal_start),
      .cal_done(cal_done), .oversample_ratio(oversample_ratio), .ramp_order(ramp_order),
      .diag_override(diag_override), .scan_busy(scan_busy));
   always #20 hclk = ~hclk;
   // The converter and calibration engine answer one cycle after each request.
   always @(posedge hclk) begin
      conv_done <= conv_req;
      cal_done  <= cal_start;
   end
   // Settled outputs are recorded mid-cycle while a sequence runs.
   always @(negedge hclk) begin
      nreq += conv_req;
      ncal += cal_start;
      if (scan_busy) begin
         {b_ramp, b_comp, b_adc, b_uni, b_osr, b_diag} = {ramp_order, conv_comp, conv_adc, conv_unipolar,
            oversample_ratio, diag_override};
      end
   end
   // One single word transfer; the answer is taken at the edge where ready is high.
   task xfer(input logic [7:0] i, input logic w, input logic [31:0] d);
      haddr <= {22'h0, i, 2'b00};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   // Request a scan with ramp order and code 2 asked for, wait it out, then clear done.
   task scan(input logic [2:0] t, input logic [1:0] amend_rdsel, input logic [13:0] dv);
      conv_data <= dv;
      nreq = 0;
      ncal = 0;
      xfer(CTRL_IDX, 1'b1, {21'h0, amend_rdsel, t, 3'h2, 1'b0, 2'b11});
      repeat (3) @(negedge hclk);
      while (scan_busy) @(negedge hclk);
      @(posedge hclk);
      xfer(STAT_IDX, 1'b1, 32'h0);
   endtask : scan
   task tally_and_finish;
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(CTRL_IDX, 1'b0, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      bipolar_mask <= 15'h0008;
      for (int t = 0; t < 8; t++) begin
         scan(t[2:0], 2'b00, 14'h0400);
         chk("override", t > 3 ? t : 0, b_diag);
         if (t < 4) chk("ramp", t == 0, b_ramp);
         if (t < 3) chk("comp", t != 0, b_comp);
         if (t < 4) chk("osr", t == 3 ? OSR_NONE : 3'h2, b_osr);
         if (t == 0 || t == 2) chk("requests", t ? NCH - 1 : NCH, nreq);
         if (t == 2) chk("unipolar", 1, b_uni);
         if (t == 3) chk("cal starts", 1, ncal + nreq);
         if (t == 0) begin
            xfer(RES_IDX, 1'b0, 32'h0);
            chk("raw ch0", 32'h400, rd);
            xfer(LOW_IDX, 1'b0, 32'h0);
            chk("raw low", 32'h400, rd);
         end
      end
      scan(3'h0, 2'b11, 14'h0800);
      xfer(RES_IDX, 1'b0, 32'h0);
      chk("filtered ch0", 32'h200, rd);
      scan(3'h0, 2'b01, 14'h1000);
      xfer(RES_IDX, 1'b0, 32'h0);
      chk("held ch0", 32'h200, rd);
      xfer(LOW_IDX, 1'b0, 32'h0);
      chk("filtered low", 32'h200, rd);
      balance_mode <= 1'b1;
      scan(3'h2, 2'b01, 14'h0400);
      balance_mode <= 1'b0;
      chk("bal adc", 2'b10, {b_adc, b_comp});
      chk("bal osr", OSR_BAL, b_osr);
      xfer(RES_IDX, 1'b0, 32'h0);
      chk("bal amend", 32'h280, rd);
      xfer(CTRL_IDX, 1'b0, 32'h0);
      chk("ctrl readback", 32'h292, rd);
      tally_and_finish;
   end
endmodule : test_scan_config_filter_routing
`default_nettype wire
